// ---- shared/eeh_pkg.sv ----
// constants for the two-wire eeprom host controller
// assumes a 10 MHz sys_clk and an apb master on the register side
package eeh_pkg;
    localparam int          CLK_NS      = 100;
    localparam int          QTR_NS      = 2500;
    // a quarter of the scl period; least time, so round up
    localparam int          QTR_CYC     = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0]  QTR_LAST    = 5'(QTR_CYC - 1);

    localparam logic [11:0] REG_CMD     = 12'h000;
    localparam logic [11:0] REG_ADDR    = 12'h004;
    localparam logic [11:0] REG_STAT    = 12'h008;
    localparam logic [11:0] REG_XFER    = 12'h00C;
    localparam logic [3:0]  REG_BUF_HI  = 4'h1;

    localparam int          CMD_OP_LSB  = 0;
    localparam int          CMD_CNT_LSB = 8;
    localparam int          ADDR_CS_LSB = 16;
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_NACK   = 1;
    localparam int          STAT_DONE   = 2;
    localparam logic [15:0] ADDR_RST    = 16'h0000;
    localparam logic [2:0]  CS_RST      = 3'h0;

    localparam logic [3:0]  DEV_ARRAY   = 4'hA;
    localparam logic [3:0]  DEV_IDENT   = 4'hB;
    localparam logic [7:0]  LOCK_DATA   = 8'h02;
    localparam int          IDENT_LOCK_SELECT_POS = 2;
    localparam logic [6:0]  PAGE_BYTES  = 7'h40;

    typedef enum logic [2:0] {
        OP_CUR_RD  = 3'b000,
        OP_RAND_RD = 3'b001,
        OP_ID_WR   = 3'b010,
        OP_ID_RD   = 3'b011,
        OP_ID_LOCK = 3'b100,
        OP_POLL    = 3'b101
    } eeh_op_t;

    typedef enum logic [1:0] {
        E_START = 2'b00,
        E_STOP  = 2'b01,
        E_WRITE = 2'b10,
        E_READ  = 2'b11
    } eeh_eng_t;
endpackage : eeh_pkg

// ---- hw/eeh_bit_engine.sv ----
// byte-level two-wire master: start, stop, write byte, read byte
// assumes open-drain pins resolved outside; pin inputs are asynchronous
module eeh_bit_engine
    import eeh_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       cmd_valid,
    input  wire eeh_eng_t   cmd,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_nack,
    output logic            cmd_ready,
    output logic            done,
    output logic [7:0]      rx_byte,
    output logic            rx_nack,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n
);
    logic [1:0] scl_s_reg;
    logic [1:0] sda_s_reg;
    logic       active_reg;
    eeh_eng_t   cmd_reg;
    logic [1:0] q_reg;
    logic [4:0] tick_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg;
    logic       ack_out_reg;
    logic       scl_low_reg;
    logic       sda_low_reg;
    logic       done_reg;
    logic [7:0] rx_byte_reg;
    logic       rx_nack_reg;
    logic       step;
    logic       bit_val;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s_reg <= 2'b11;
            sda_s_reg <= 2'b11;
        end
        else
        begin
            scl_s_reg <= {scl_s_reg[0], scl_in};
            sda_s_reg <= {sda_s_reg[0], sda_in};
        end
    end

    // quarter two waits for scl really high, so a stretching target holds us
    assign step = active_reg && (tick_reg == QTR_LAST) && !(q_reg == 2'd2 && !scl_s_reg[1]);
    assign bit_val = (cmd_reg == E_WRITE) ? ((bit_reg < 4'd8) ? sh_reg[7] : 1'b1)
                                          : ((bit_reg < 4'd8) ? 1'b1 : ack_out_reg);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_reg <= 5'h00;
        else if (!active_reg || step)
            tick_reg <= 5'h00;
        else if (tick_reg != QTR_LAST)
            tick_reg <= tick_reg + 5'h01;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_reg  <= 1'b0;
            cmd_reg     <= E_START;
            q_reg       <= 2'd0;
            bit_reg     <= 4'h0;
            sh_reg      <= 8'h00;
            ack_out_reg <= 1'b1;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            done_reg    <= 1'b0;
            rx_byte_reg <= 8'h00;
            rx_nack_reg <= 1'b1;
        end
        else
        begin
            done_reg <= 1'b0;
            if (!active_reg)
            begin
                if (cmd_valid)
                begin
                    active_reg  <= 1'b1;
                    cmd_reg     <= cmd;
                    q_reg       <= 2'd0;
                    bit_reg     <= 4'h0;
                    sh_reg      <= tx_byte;
                    ack_out_reg <= tx_nack;
                end
            end
            else if (step)
            begin
                q_reg <= q_reg + 2'd1;
                case (cmd_reg)
                    E_START:
                    begin
                        case (q_reg)
                            2'd0: sda_low_reg <= 1'b0;
                            2'd1: scl_low_reg <= 1'b0;
                            2'd2: sda_low_reg <= 1'b1;
                            default:
                            begin
                                scl_low_reg <= 1'b1;
                                active_reg  <= 1'b0;
                                done_reg    <= 1'b1;
                            end
                        endcase
                    end
                    E_STOP:
                    begin
                        case (q_reg)
                            2'd0: sda_low_reg <= 1'b1;
                            2'd1: scl_low_reg <= 1'b0;
                            2'd2: sda_low_reg <= 1'b0;
                            default:
                            begin
                                active_reg <= 1'b0;
                                done_reg   <= 1'b1;
                            end
                        endcase
                    end
                    default:
                    begin
                        case (q_reg)
                            2'd0: sda_low_reg <= ~bit_val;
                            2'd1: scl_low_reg <= 1'b0;
                            2'd2:
                            begin
                                if (bit_reg < 4'd8)
                                    sh_reg <= {sh_reg[6:0], sda_s_reg[1]};
                                else
                                    rx_nack_reg <= sda_s_reg[1];
                            end
                            default:
                            begin
                                scl_low_reg <= 1'b1;
                                if (bit_reg == 4'd8)
                                begin
                                    active_reg  <= 1'b0;
                                    done_reg    <= 1'b1;
                                    rx_byte_reg <= sh_reg;
                                end
                                else
                                    bit_reg <= bit_reg + 4'h1;
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    assign cmd_ready = !active_reg;
    assign done      = done_reg;
    assign rx_byte   = rx_byte_reg;
    assign rx_nack   = rx_nack_reg;
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign scl_oe_n  = !scl_low_reg;
    assign sda_oe_n  = !sda_low_reg;
endmodule : eeh_bit_engine

// ---- hw/eeh_host.sv ----
// apb-controlled host for a two-wire eeprom with an identification page
// assumes open-drain pull-ups outside and an apb master on sys_clk
module eeh_host
    import eeh_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n
);
    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,
        S_START  = 4'b0001,
        S_DEV    = 4'b0010,
        S_ADH    = 4'b0011,
        S_ADL    = 4'b0100,
        S_WDAT   = 4'b0101,
        S_RSTART = 4'b0110,
        S_DEVR   = 4'b0111,
        S_RDAT   = 4'b1000,
        S_STOP   = 4'b1001,
        S_PSTART = 4'b1010,
        S_PDEV   = 4'b1011,
        S_PSTOP  = 4'b1100
    } eeh_state_t;

    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    eeh_state_t  state_reg;
    eeh_op_t     op_reg;
    logic [6:0]  cnt_reg;
    logic [6:0]  xfer_reg;
    logic        issued_reg;
    logic        poll_ok_reg;
    logic [15:0] addr_reg;
    logic [2:0]  cs_reg;
    logic        nack_reg;
    logic        done_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic [7:0]  buf_mem [0:63];

    logic        wr_en;
    logic        buf_hit;
    logic        start_cmd;
    logic        busy;
    logic        ident_op;
    logic        rd_op;
    logic        wr_op;
    logic        last;
    logic [6:0]  req_cnt;
    logic [6:0]  room;
    logic [6:0]  eff_cnt;
    logic [3:0]  dev_type;
    logic [7:0]  addr_hi;
    logic [7:0]  addr_lo;
    logic        ack_fail;
    logic        fin;
    logic [31:0] rd_val;
    logic        rd_err;

    eeh_eng_t    eng_cmd;
    logic [7:0]  eng_tx;
    logic        eng_nack;
    logic        eng_valid;
    logic        eng_ready;
    logic        eng_done;
    logic [7:0]  eng_rx_byte;
    logic        eng_rx_nack;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    assign busy     = (state_reg != S_IDLE);
    assign wr_en    = psel && penable && pwrite;
    assign buf_hit  = (paddr[11:8] == REG_BUF_HI) && (paddr[1:0] == 2'b00);
    assign start_cmd = wr_en && (paddr == REG_CMD) && !busy
                       && (pwdata[CMD_OP_LSB +: 3] <= OP_POLL);

    assign ident_op = (op_reg == OP_ID_WR) || (op_reg == OP_ID_RD) || (op_reg == OP_ID_LOCK);
    assign rd_op    = (op_reg == OP_RAND_RD) || (op_reg == OP_ID_RD);
    assign wr_op    = (op_reg == OP_ID_WR) || (op_reg == OP_ID_LOCK);
    assign last     = ((xfer_reg + 7'h01) >= cnt_reg);
    assign dev_type = ident_op ? DEV_IDENT : DEV_ARRAY;

    // byte count: zero means one, never more than a page
    assign req_cnt = pwdata[CMD_CNT_LSB +: 7];
    assign room    = PAGE_BYTES - {1'b0, addr_reg[5:0]};
    always_comb
    begin
        eff_cnt = (req_cnt == 7'h00) ? 7'h01 : req_cnt;
        if (eff_cnt > PAGE_BYTES)
            eff_cnt = PAGE_BYTES;
        if (pwdata[CMD_OP_LSB +: 3] == OP_ID_RD && eff_cnt > room)
            eff_cnt = room;
        if (pwdata[CMD_OP_LSB +: 3] == OP_ID_LOCK)
            eff_cnt = 7'h01;
    end

    // id accesses send only the offset and the lock select bit
    always_comb
    begin
        addr_hi = {1'b0, addr_reg[14:8]};
        addr_lo = addr_reg[7:0];
        if (ident_op)
        begin
            addr_hi = 8'h00;
            addr_hi[IDENT_LOCK_SELECT_POS] = (op_reg == OP_ID_LOCK);
            addr_lo = {2'b00, addr_reg[5:0]};
        end
    end

    always_comb
    begin
        eng_cmd  = E_WRITE;
        eng_tx   = 8'hFF;
        eng_nack = 1'b1;
        case (state_reg)
            S_START, S_RSTART, S_PSTART: eng_cmd = E_START;
            S_STOP, S_PSTOP:             eng_cmd = E_STOP;
            S_DEV, S_PDEV:               eng_tx  = {dev_type, cs_reg, 1'b0};
            S_DEVR:                      eng_tx  = {dev_type, cs_reg, 1'b1};
            S_ADH:                       eng_tx  = addr_hi;
            S_ADL:                       eng_tx  = addr_lo;
            S_WDAT:
                eng_tx = (op_reg == OP_ID_LOCK) ? LOCK_DATA : buf_mem[xfer_reg[5:0]];
            S_RDAT:
            begin
                eng_cmd  = E_READ;
                eng_nack = last;
            end
            default: eng_cmd = E_WRITE;
        endcase
    end
    assign eng_valid = busy && !issued_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg   <= S_IDLE;
            op_reg      <= OP_CUR_RD;
            cnt_reg     <= 7'h00;
            xfer_reg    <= 7'h00;
            issued_reg  <= 1'b0;
            poll_ok_reg <= 1'b0;
        end
        else
        begin
            if (eng_valid && eng_ready)
                issued_reg <= 1'b1;
            else if (eng_done)
                issued_reg <= 1'b0;
            if (start_cmd)
            begin
                op_reg    <= eeh_op_t'(pwdata[CMD_OP_LSB +: 3]);
                cnt_reg   <= eff_cnt;
                xfer_reg  <= 7'h00;
                state_reg <= S_START;
            end
            else if (eng_done)
            begin
                case (state_reg)
                    S_START:
                        state_reg <= (op_reg == OP_CUR_RD) ? S_DEVR : S_DEV;
                    S_DEV:
                        state_reg <= (eng_rx_nack || op_reg == OP_POLL) ? S_STOP : S_ADH;
                    S_ADH:
                        state_reg <= eng_rx_nack ? S_STOP : S_ADL;
                    S_ADL:
                        if (eng_rx_nack)
                            state_reg <= S_STOP;
                        else
                            state_reg <= rd_op ? S_RSTART : S_WDAT;
                    S_WDAT:
                    begin
                        xfer_reg <= xfer_reg + 7'h01;
                        if (eng_rx_nack || last)
                            state_reg <= S_STOP;
                    end
                    S_RSTART:
                        state_reg <= S_DEVR;
                    S_DEVR:
                        state_reg <= eng_rx_nack ? S_STOP : S_RDAT;
                    S_RDAT:
                    begin
                        xfer_reg <= xfer_reg + 7'h01;
                        if (last)
                            state_reg <= S_STOP;
                    end
                    S_STOP:
                        // a completed write starts the device's internal cycle
                        state_reg <= (wr_op && !nack_reg) ? S_PSTART : S_IDLE;
                    S_PSTART:
                        state_reg <= S_PDEV;
                    S_PDEV:
                    begin
                        poll_ok_reg <= !eng_rx_nack;
                        state_reg   <= S_PSTOP;
                    end
                    S_PSTOP:
                        // no poll limit: a dead device keeps the host busy
                        state_reg <= poll_ok_reg ? S_IDLE : S_PSTART;
                    default:
                        state_reg <= S_IDLE;
                endcase
            end
        end
    end

    assign ack_fail = eng_done && eng_rx_nack
                      && (state_reg == S_DEV || state_reg == S_ADH || state_reg == S_ADL
                          || state_reg == S_WDAT || state_reg == S_DEVR);
    assign fin = eng_done && ((state_reg == S_STOP && !(wr_op && !nack_reg))
                              || (state_reg == S_PSTOP && poll_ok_reg));

    // start only happens while idle, so it never meets a set in one cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nack_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            if (ack_fail)
                nack_reg <= 1'b1;
            else if (start_cmd)
                nack_reg <= 1'b0;
            if (fin)
                done_reg <= 1'b1;
            else if (start_cmd)
                done_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg <= ADDR_RST;
            cs_reg   <= CS_RST;
        end
        else if (wr_en && paddr == REG_ADDR && !busy)
        begin
            addr_reg <= pwdata[15:0];
            cs_reg   <= pwdata[ADDR_CS_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (eng_done && state_reg == S_RDAT)
            buf_mem[xfer_reg[5:0]] <= eng_rx_byte;
        else if (wr_en && buf_hit && !busy)
            buf_mem[paddr[7:2]] <= pwdata[7:0];
    end

    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (buf_hit)
            rd_val[7:0] = buf_mem[paddr[7:2]];
        else
        begin
            case (paddr)
                REG_CMD:
                begin
                    rd_val[CMD_OP_LSB +: 3]  = op_reg;
                    rd_val[CMD_CNT_LSB +: 7] = cnt_reg;
                end
                REG_ADDR: rd_val = {13'h0000, cs_reg, addr_reg};
                REG_STAT:
                begin
                    rd_val[STAT_BUSY] = busy;
                    rd_val[STAT_NACK] = nack_reg;
                    rd_val[STAT_DONE] = done_reg;
                end
                REG_XFER: rd_val[6:0] = xfer_reg;
                default:  rd_err = 1'b1;
            endcase
        end
    end

    // answer registered in the setup cycle, ready in the first access cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_reg <= rd_err;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign pready  = psel && penable;

    eeh_bit_engine u_engine (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .cmd_valid (eng_valid),
        .cmd       (eng_cmd),
        .tx_byte   (eng_tx),
        .tx_nack   (eng_nack),
        .cmd_ready (eng_ready),
        .done      (eng_done),
        .rx_byte   (eng_rx_byte),
        .rx_nack   (eng_rx_nack),
        .scl_in    (scl_in),
        .scl_out   (scl_out),
        .scl_oe_n  (scl_oe_n),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe_n  (sda_oe_n)
    );
endmodule : eeh_host

// ---- bench/eeh_host_properties.sv ----
// port assertions for eeh_host
// assumes it is bound into eeh_host on sys_clk
module eeh_host_properties
    import eeh_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_out,
    input wire logic        scl_oe_n,
    input wire logic        sda_out,
    input wire logic        sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int lo_cnt;
    int hi_cnt;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // phase lengths of the clock line, held low or released
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            {lo_cnt, hi_cnt} <= {32'h0, 32'h0};
        else
            {lo_cnt, hi_cnt} <= scl_oe_n ? {32'h0, hi_cnt + 1} : {lo_cnt + 1, 32'h0};
    sequence start_seq;
        $fell(sda_oe_n) && scl_oe_n;
    endsequence
    sequence stop_seq;
        $rose(sda_oe_n) && scl_oe_n;
    endsequence
    chk_ready_comb: assert property (pready == (psel && penable))
        else $error("pready differs from psel and penable");
    chk_unmapped_err: assert property (psel && penable && paddr == 12'h200 |-> pslverr)
        else $error("no error on unmapped address");
    chk_wr_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on a write");
    chk_pins_low: assert property (!scl_out && !sda_out)
        else $error("open-drain level not low");
    chk_scl_low_time: assert property ($rose(scl_oe_n) |-> lo_cnt >= QTR_CYC)
        else $error("clock low phase too short");
    chk_scl_high_time: assert property ($fell(scl_oe_n) |-> hi_cnt >= QTR_CYC)
        else $error("clock high phase too short");
    chk_start_clock: assert property (start_seq |-> ##[1:60] !scl_oe_n)
        else $error("no clock after start");
    chk_stop_idle: assert property (stop_seq |=> sda_oe_n [*8])
        else $error("data line taken right after stop");
endmodule : eeh_host_properties

// ---- bench/eeh_dev_model.sv ----
// behavioural eeprom with identification page on the two-wire lines
// assumes the bench resolves the open-drain wires; no clock stretching
module eeh_dev_model
#(
    parameter int         TWR_NS = 200000,
    parameter logic [2:0] CS     = 3'h0
)
(
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  id_mem [64];
    logic [7:0]  sh, hi, dat;
    logic [14:0] ptr = 15'h0000;
    logic [3:0]  n = 4'h0;
    logic [2:0]  ph = 3'h0;
    logic        idp, lk_cmd;
    logic        busy = 1'b0;
    logic        wr = 1'b0;
    logic        locked = 1'b0; // no path ever clears it
    initial
    begin
        sda_oe_n = 1'b1;
        foreach (id_mem[i]) id_mem[i] = 8'h00;
    end
    always @(negedge sda) if (scl) {ph, n} = {3'h1, 4'h0};
    always @(posedge sda) if (scl) {busy, wr, ph} = {busy | wr, 1'b0, 3'h0};
    always @(posedge busy) #(TWR_NS) busy = 1'b0;
    always @(posedge scl)
        if (ph != 3'h0)
        begin
            if (n < 4'h8) sh = {sh[6:0], sda};
            else if (ph == 3'h5 && sda) ph = 3'h0;
            n = (n < 4'h8) ? n + 4'h1 : 4'h0;
        end
    always @(negedge scl)
    begin
        sda_oe_n = 1'b1;
        if (ph == 3'h5 && n < 4'h8)
        begin
            if (n == 4'h0) dat = idp ? id_mem[ptr[5:0]] : ptr[7:0] ^ 8'h5A;
            sda_oe_n = dat[3'h7 - n[2:0]];
        end
        else if (ph == 3'h5)
            ptr = idp ? {ptr[14:6], ptr[5:0] + 6'h01} : ptr + 15'h0001;
        else if (ph != 3'h0 && n == 4'h8)
        begin
            sda_oe_n = 1'b0;
            case (ph)
                3'h1: if (sh[7:5] != 3'h5 || sh[3:1] != CS || busy)
                          {sda_oe_n, ph} = {1'b1, 3'h0};
                      else {idp, ph} = {sh[4], sh[0] ? 3'h5 : 3'h2};
                3'h2: {hi, ph} = {sh, 3'h3};
                3'h3: {ptr, lk_cmd, ph} = {hi[6:0], sh, idp & hi[2], 3'h4};
                default:
                    if (!idp || (locked && !lk_cmd)) {sda_oe_n, ph} = {1'b1, 3'h0};
                    else if (lk_cmd) {locked, wr} = {locked | sh[1], 1'b1};
                    else
                    begin
                        id_mem[ptr[5:0]] = sh;
                        {ptr[5:0], wr} = {ptr[5:0] + 6'h01, 1'b1};
                    end
            endcase
        end
    end
endmodule : eeh_dev_model

// ---- bench/tb.sv ----
// bench: eeh_host on apb, eeprom model on the wires
// assumes the model and checker files are compiled first
module tb
    import eeh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {eeh_op_t op; logic [31:0] adr; logic [6:0] cnt, xfer;
                    logic nack; logic [7:0] b0, b1;} eeh_row_t;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, scl_out, scl_oe_n, sda_out, sda_oe_n, dev_oe_n;
    int          n_errors = 0;
    int          samples_checked = 0;
    wire         scl = scl_oe_n; // pulled up unless held low
    wire         sda = sda_oe_n & dev_oe_n;
    eeh_row_t rows [5] = '{
        '{OP_ID_WR, 32'h0000003E, 7'h04, 7'h04, 1'b0, 8'hC0, 8'hC1},
        '{OP_ID_RD, 32'h0000003F, 7'h04, 7'h01, 1'b0, 8'hC1, 8'hC1},
        '{OP_RAND_RD, 32'h00007FFF, 7'h02, 7'h02, 1'b0, 8'hA5, 8'h5A},
        '{OP_CUR_RD, 32'h00000000, 7'h01, 7'h01, 1'b0, 8'h5B, 8'h5A},
        '{OP_POLL, 32'h00030000, 7'h01, 7'h00, 1'b1, 8'h5B, 8'h5A}
    };
    always #50 sys_clk = ~sys_clk;
    eeh_host eeh_host_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
    eeh_dev_model eeh_dev_model_inst (.scl(scl), .sda(sda), .sda_oe_n(dev_oe_n));
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one transfer; the answer is taken only at the edge that sees pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        for (k = 0; pready !== 1'b1 && k < 16; k++) @(posedge sys_clk);
        if (k == 16) {n_errors, samples_checked} = {n_errors + 1, samples_checked};
        if (k == 16) end_sim();
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic run(input eeh_row_t r);
        int k;
        apb(1'b1, REG_ADDR, r.adr);
        apb(1'b1, REG_CMD, {17'h0, r.cnt, 5'h0, r.op});
        // bound ends the whole run on a hung op after 10000 status reads
        for (k = 0; k < 10000 && rd[STAT_DONE] !== 1'b1; k++) apb(1'b0, REG_STAT, 32'h0);
        if (k == 10000) n_errors++;
        if (k == 10000) end_sim();
        chk("nack", {31'h0, r.nack}, {31'h0, rd[STAT_NACK]});
        apb(1'b0, REG_XFER, 32'h0);
        if (r.xfer !== 7'h7F) chk("xfer", {25'h0, r.xfer}, rd);
        apb(1'b0, 12'h100, 32'h0);
        chk("byte0", {24'h0, r.b0}, rd);
        apb(1'b0, 12'h104, 32'h0);
        chk("byte1", {24'h0, r.b1}, rd);
        $display("op %0d done", r.op);
    endtask : run
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, REG_STAT, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b0, REG_ADDR, 32'h0);
        chk("addr", {13'h0, CS_RST, ADDR_RST}, rd);
        $display("reset values done");
        for (int i = 0; i < 4; i++) apb(1'b1, 12'h100 + 12'(4 * i), 32'hC0 + i);
        foreach (rows[i]) run(rows[i]);
        // awkward cases: lock, then a refused write to the locked page
        run('{OP_ID_LOCK, 32'h0, 7'h01, 7'h7F, 1'b0, 8'h5B, 8'h5A});
        chk("locked", 32'h1, {31'h0, eeh_dev_model_inst.locked});
        run('{OP_ID_WR, 32'h0, 7'h01, 7'h7F, 1'b1, 8'h5B, 8'h5A});
        chk("id byte", 32'hC2, {24'h0, eeh_dev_model_inst.id_mem[0]});
        apb(1'b0, 12'h200, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        $display("lock and error cases done");
        // status and command hold values from the refused write; reset must clear them
        rstn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, REG_STAT, 32'h0);
        chk("status after reset", 32'h0, rd);
        apb(1'b0, REG_CMD, 32'h0);
        chk("cmd after reset", 32'h0, rd);
        $display("mid-run reset done");
        end_sim();
    end
endmodule : tb
bind eeh_host eeh_host_properties eeh_host_properties_inst (.sys_clk(sys_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));
